// ===== logic/ppf_pkg.sv
/*
  package for the phase, fault and trigger control block of one pulse-width
  generator channel: register indices, field positions, reset values, modes.
  assumes a 16-bit register port with one-cycle read latency.
*/
package ppf_pkg;
  // ==========================================================================
  // register map (word index on the register port)
  localparam logic [2:0] ADDR_PHASE = 3'h0;
  localparam logic [2:0] ADDR_IOCTL = 3'h1;
  localparam logic [2:0] ADDR_TRIG = 3'h2;
  localparam logic [2:0] ADDR_FAULT = 3'h3;
  localparam logic [2:0] ADDR_STRIG = 3'h4;
  localparam logic [2:0] ADDR_GENCTL = 3'h5;
  localparam logic [2:0] ADDR_STATUS = 3'h6;
  // ==========================================================================
  // reset values, local period limit and compare mask
  localparam logic [15:0] PHASE_RST = 16'h0000;
  localparam logic [15:0] IOCTL_RST = 16'h0000;
  localparam logic [15:0] TRIG_RST = 16'h0000;
  localparam logic [15:0] FAULT_RST = 16'h0003;
  localparam logic [15:0] GENCTL_RST = 16'h0000;
  localparam logic [15:0] LOCAL_PERIOD_MAX = 16'hFFF8;
  localparam logic [15:0] TRIG_MASK = 16'hFFF8;
  // ==========================================================================
  // field positions, input counts and fault source code range
  localparam int IO_MODE_LO = 10;
  localparam int IO_CURRENT_LIMIT_DATA_HI = 3;
  localparam int IO_CURRENT_LIMIT_DATA_LO = 2;
  localparam int IO_SWAP = 1;
  localparam int IO_OVERRIDE_SYNC = 0;
  localparam int IO_OVR_EN_H = 9;
  localparam int IO_OVR_EN_L = 8;
  localparam int IO_OVERRIDE_DATA_H = 7;
  localparam int IO_OVERRIDE_DATA_L = 6;
  localparam int IO_FLTDAT_H = 5;
  localparam int IO_FLTDAT_L = 4;
  localparam int FC_INDEP = 15;
  localparam int FC_CLEN = 8;
  localparam int FC_SRC_LO = 3;
  localparam int FC_POL = 2;
  localparam int GC_ITB = 9;
  localparam int GC_IUE = 0;
  localparam int GC_HIGH_SIDE_POLARITY = 1;
  localparam int GC_POLL = 2;
  localparam int GC_CLR_LATCH = 3;
  localparam int NUM_FAULT = 12;
  localparam int NUM_CMP = 4;
  localparam logic [4:0] SRC_FIRST = 5'h01;
  localparam logic [4:0] SRC_LAST = 5'h10;
  // ==========================================================================
  // enumerations and the output pair type
  typedef enum logic [1:0] {
    MODE_COMPL = 2'b00,
    MODE_REDUN = 2'b01,
    MODE_PUSHPULL = 2'b10,
    MODE_INDEP = 2'b11
  } ppf_outmode_t;
  typedef enum logic [1:0] {
    FLT_LATCHED = 2'b00,
    FLT_CYCLE = 2'b01,
    FLT_RESERVED = 2'b10,
    FLT_OFF = 2'b11
  } ppf_fltmode_t;
  typedef struct packed {
    logic high;
    logic low;
  } ppf_pair_t;
endpackage

// ===== logic/ppf_channel.sv
/*
  phase, fault and trigger control of one pulse-width generator channel.
  assumes pulse-width generator signals and time base on sys_clk; fault and
  comparator inputs are asynchronous and are synchronised here.
*/
`timescale 1ns/1ns
module ppf_channel #(
  parameter int DW = 16
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [2:0] regAddr,
  input wire logic [DW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [DW-1:0] regRdata,
  input wire logic moduleEnable,
  input wire logic [DW-1:0] masterPeriod,
  input wire logic masterBoundary,
  input wire ppf_pkg::ppf_pair_t genRaw,
  input wire logic [ppf_pkg::NUM_FAULT-1:0] faultPins,
  input wire logic [ppf_pkg::NUM_CMP-1:0] cmpOuts,
  input wire logic currentLimit,
  output ppf_pkg::ppf_pair_t pinOut,
  output logic [DW-1:0] phaseHigh,
  output logic [DW-1:0] phaseLow,
  output logic [DW-1:0] localPeriod,
  output logic localBoundary,
  output logic adcTrigger,
  output logic trigIrq
);
  // ==========================================================================
  // registers
  logic [DW-1:0] phase_ff, phaseAct_ff, ioctl_ff, trig_ff, strig_ff, fault_ff, genctl_ff;
  logic [DW-1:0] tb_ff;
  logic [15:0] syncA_ff, syncB_ff;
  logic fltLatch_ff, fltForce_ff;
  ppf_pkg::ppf_pair_t ovrAct_ff, ovrEnAct_ff;
  logic independent_time_base_select, immediate_update, boundary, srcRaw, srcValid, srcActive, clrLatch;
  ppf_pkg::ppf_outmode_t omode;
  ppf_pkg::ppf_fltmode_t fmode;
  logic [4:0] src;
  logic [DW-1:0] phaseClip;
  ppf_pkg::ppf_pair_t swapped, shaped, nxt_pin;

  assign independent_time_base_select = genctl_ff[ppf_pkg::GC_ITB];
  assign immediate_update = genctl_ff[ppf_pkg::GC_IUE];
  assign omode = ppf_pkg::ppf_outmode_t'(ioctl_ff[ppf_pkg::IO_MODE_LO+1:ppf_pkg::IO_MODE_LO]);
  assign fmode = ppf_pkg::ppf_fltmode_t'(fault_ff[1:0]);
  assign src = fault_ff[ppf_pkg::FC_SRC_LO+4:ppf_pkg::FC_SRC_LO];
  assign clrLatch = regWr && regAddr == ppf_pkg::ADDR_GENCTL && regWdata[ppf_pkg::GC_CLR_LATCH];
  // local period limit when used as period
  assign phaseClip = (regWdata > ppf_pkg::LOCAL_PERIOD_MAX) ? ppf_pkg::LOCAL_PERIOD_MAX : regWdata;

  // ==========================================================================
  // register writes
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      phase_ff <= ppf_pkg::PHASE_RST;
      ioctl_ff <= ppf_pkg::IOCTL_RST;
      trig_ff <= ppf_pkg::TRIG_RST;
      strig_ff <= ppf_pkg::TRIG_RST;
      fault_ff <= ppf_pkg::FAULT_RST;
      genctl_ff <= ppf_pkg::GENCTL_RST;
    end else if (regWr) begin
      if (regAddr == ppf_pkg::ADDR_PHASE) begin
        phase_ff <= independent_time_base_select ? phaseClip : regWdata;
      end else if (regAddr == ppf_pkg::ADDR_IOCTL) begin
        ioctl_ff <= regWdata;
      end else if (regAddr == ppf_pkg::ADDR_TRIG) begin
        trig_ff <= regWdata & ppf_pkg::TRIG_MASK;
      end else if (regAddr == ppf_pkg::ADDR_FAULT) begin
        fault_ff <= regWdata;
      end else if (regAddr == ppf_pkg::ADDR_STRIG) begin
        strig_ff <= regWdata & ppf_pkg::TRIG_MASK;
      end else if (regAddr == ppf_pkg::ADDR_GENCTL) begin
        genctl_ff <= regWdata & ~(DW'(1) << ppf_pkg::GC_CLR_LATCH);
      end
    end
  end

  // ==========================================================================
  // register reads, one cycle later
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      regRdata <= '0;
    end else if (regRd) begin
      if (regAddr == ppf_pkg::ADDR_PHASE) begin
        regRdata <= phase_ff;
      end else if (regAddr == ppf_pkg::ADDR_IOCTL) begin
        regRdata <= ioctl_ff;
      end else if (regAddr == ppf_pkg::ADDR_TRIG) begin
        regRdata <= trig_ff;
      end else if (regAddr == ppf_pkg::ADDR_FAULT) begin
        regRdata <= fault_ff;
      end else if (regAddr == ppf_pkg::ADDR_STRIG) begin
        regRdata <= strig_ff;
      end else if (regAddr == ppf_pkg::ADDR_GENCTL) begin
        regRdata <= genctl_ff;
      end else if (regAddr == ppf_pkg::ADDR_STATUS) begin
        regRdata <= {13'h0000, fltForce_ff, fltLatch_ff, srcActive};
      end else begin
        regRdata <= '0;
      end
    end else begin
      regRdata <= '0;
    end
  end

  // ==========================================================================
  // local time base counter, runs only in independent time base mode
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tb_ff <= '0;
    end else if (!moduleEnable || !independent_time_base_select || tb_ff >= phaseAct_ff) begin
      tb_ff <= '0;
    end else begin
      tb_ff <= tb_ff + DW'(1);
    end
  end
  assign localBoundary = moduleEnable && independent_time_base_select && tb_ff >= phaseAct_ff;
  assign boundary = independent_time_base_select ? localBoundary : masterBoundary;

  // active phase/period copy: immediate, at the time base boundary, or every clock while the module is disabled
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      phaseAct_ff <= ppf_pkg::PHASE_RST;
    end else if (immediate_update || boundary || !moduleEnable) begin
      phaseAct_ff <= phase_ff;
    end
  end

  // offset limited to the master period when used as phase
  always_comb begin
    localPeriod = independent_time_base_select ? phaseAct_ff : masterPeriod;
    phaseHigh = (!independent_time_base_select && phaseAct_ff > masterPeriod) ? masterPeriod : phaseAct_ff;
    phaseLow = (omode == ppf_pkg::MODE_INDEP) ? '0 : phaseHigh;
  end

  // ==========================================================================
  // trigger compares, local time base only
  assign adcTrigger = independent_time_base_select && moduleEnable &&
                      (tb_ff == trig_ff || tb_ff == strig_ff);
  assign trigIrq = independent_time_base_select && moduleEnable && tb_ff == trig_ff;

  // ==========================================================================
  // two-stage synchronisers for fault pins and comparator outputs
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      syncA_ff <= '0;
      syncB_ff <= '0;
    end else begin
      syncA_ff <= {cmpOuts, faultPins};
      syncB_ff <= syncA_ff;
    end
  end

  // fault source select and polarity
  always_comb begin
    srcValid = src >= ppf_pkg::SRC_FIRST && src <= ppf_pkg::SRC_LAST;
    srcRaw = srcValid ? syncB_ff[4'(src - 5'h01)] : 1'b0;
    srcActive = srcValid && (fault_ff[ppf_pkg::FC_POL] ? !srcRaw : srcRaw);
  end

  // latched flag: set wins over clear
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      fltLatch_ff <= 1'b0;
    end else if (fmode == ppf_pkg::FLT_LATCHED && srcActive) begin
      fltLatch_ff <= 1'b1;
    end else if (clrLatch || fmode != ppf_pkg::FLT_LATCHED) begin
      fltLatch_ff <= 1'b0;
    end
  end

  // force state per mode
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      fltForce_ff <= 1'b0;
    end else if (fmode == ppf_pkg::FLT_CYCLE) begin
      if (srcActive) begin
        fltForce_ff <= 1'b1;
      end else if (boundary) begin
        fltForce_ff <= 1'b0;
      end
    end else if (fmode == ppf_pkg::FLT_LATCHED) begin
      fltForce_ff <= srcActive || fltLatch_ff;
    end else begin
      fltForce_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // override data: applied at boundary when sync, else next clock
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ovrAct_ff <= '0;
      ovrEnAct_ff <= '0;
    end else if (!ioctl_ff[ppf_pkg::IO_OVERRIDE_SYNC] || boundary) begin
      ovrAct_ff <= {ioctl_ff[ppf_pkg::IO_OVERRIDE_DATA_H], ioctl_ff[ppf_pkg::IO_OVERRIDE_DATA_L]};
      ovrEnAct_ff <= {ioctl_ff[ppf_pkg::IO_OVR_EN_H], ioctl_ff[ppf_pkg::IO_OVR_EN_L]};
    end
  end

  // output priority: fault, current limit, override, generator after swap; polarity
  always_comb begin
    swapped = ioctl_ff[ppf_pkg::IO_SWAP] ? ppf_pkg::ppf_pair_t'({genRaw.low, genRaw.high}) : genRaw;
    shaped.high = ovrEnAct_ff.high ? ovrAct_ff.high : swapped.high;
    shaped.low = ovrEnAct_ff.low ? ovrAct_ff.low : swapped.low;
    if (fltForce_ff) begin
      shaped = {ioctl_ff[ppf_pkg::IO_FLTDAT_H], ioctl_ff[ppf_pkg::IO_FLTDAT_L]};
    end else if (currentLimit && fault_ff[ppf_pkg::FC_CLEN] && !fault_ff[ppf_pkg::FC_INDEP]) begin
      shaped = {ioctl_ff[ppf_pkg::IO_CURRENT_LIMIT_DATA_HI], ioctl_ff[ppf_pkg::IO_CURRENT_LIMIT_DATA_LO]};
    end
    nxt_pin.high = shaped.high ^ genctl_ff[ppf_pkg::GC_HIGH_SIDE_POLARITY];
    nxt_pin.low = shaped.low ^ genctl_ff[ppf_pkg::GC_POLL];
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pinOut <= '0;
    end else begin
      pinOut <= nxt_pin;
    end
  end

  // ==========================================================================
  // checks

  // compare registers keep their low bits at zero
  chk_trig_low_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    trig_ff[2:0] == 3'h0 && strig_ff[2:0] == 3'h0)
    else $error("compare low bits not zero");
  // primary compare write keeps the upper thirteen bits
  chk_trig_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    regWr && regAddr == ppf_pkg::ADDR_TRIG |=> trig_ff == ($past(regWdata) & ppf_pkg::TRIG_MASK))
    else $error("primary compare write lost");
  // secondary compare write keeps the upper thirteen bits
  chk_strig_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    regWr && regAddr == ppf_pkg::ADDR_STRIG |=> strig_ff == ($past(regWdata) & ppf_pkg::TRIG_MASK))
    else $error("secondary compare write lost");

  // phase register meaning and limits
  chk_period_limit: assert property (@(posedge sys_clk) disable iff (!resetn)
    regWr && regAddr == ppf_pkg::ADDR_PHASE && independent_time_base_select |=> phase_ff <= ppf_pkg::LOCAL_PERIOD_MAX)
    else $error("local period over limit");
  chk_itb_period: assert property (@(posedge sys_clk) disable iff (!resetn)
    independent_time_base_select |-> localPeriod == phaseAct_ff)
    else $error("local period not from phase register");
  chk_indep_low: assert property (@(posedge sys_clk) disable iff (!resetn)
    omode == ppf_pkg::MODE_INDEP |-> phaseLow == '0)
    else $error("low phase in independent mode");
  chk_both_phase: assert property (@(posedge sys_clk) disable iff (!resetn)
    omode != ppf_pkg::MODE_INDEP |-> phaseLow == phaseHigh)
    else $error("phase not shared");
  chk_offset_range: assert property (@(posedge sys_clk) disable iff (!resetn)
    !independent_time_base_select |-> phaseHigh <= masterPeriod)
    else $error("offset beyond period");

  // update timing of the active phase copy
  chk_iue_take: assert property (@(posedge sys_clk) disable iff (!resetn)
    immediate_update |=> phaseAct_ff == $past(phase_ff))
    else $error("immediate update not taken");
  chk_hold_update: assert property (@(posedge sys_clk) disable iff (!resetn)
    !immediate_update && !boundary && moduleEnable |=> $stable(phaseAct_ff))
    else $error("phase changed off boundary");
  chk_boundary_wrap: assert property (@(posedge sys_clk) disable iff (!resetn)
    localBoundary |=> tb_ff == '0)
    else $error("local counter did not wrap");

  // converter triggers and interrupt
  chk_irq_primary: assert property (@(posedge sys_clk) disable iff (!resetn)
    independent_time_base_select && moduleEnable && tb_ff == trig_ff |-> trigIrq && adcTrigger)
    else $error("primary match lost");
  chk_adc_second: assert property (@(posedge sys_clk) disable iff (!resetn)
    independent_time_base_select && moduleEnable && tb_ff == strig_ff |-> adcTrigger)
    else $error("secondary match lost");
  chk_strig_noirq: assert property (@(posedge sys_clk) disable iff (!resetn)
    trigIrq |-> tb_ff == trig_ff)
    else $error("irq without primary match");
  chk_no_master_trig: assert property (@(posedge sys_clk) disable iff (!resetn)
    !independent_time_base_select |-> !adcTrigger && !trigIrq)
    else $error("trigger without local time base");

  // fault source selection and polarity
  chk_src_reserved: assert property (@(posedge sys_clk) disable iff (!resetn)
    !srcValid |-> !srcActive)
    else $error("reserved source active");
  chk_pol_low: assert property (@(posedge sys_clk) disable iff (!resetn)
    srcValid && fault_ff[ppf_pkg::FC_POL] |-> srcActive == !srcRaw)
    else $error("active low source misread");

  // fault modes
  chk_flt_off: assert property (@(posedge sys_clk) disable iff (!resetn)
    fmode == ppf_pkg::FLT_OFF |=> !fltForce_ff)
    else $error("fault forced while disabled");
  chk_reserved_off: assert property (@(posedge sys_clk) disable iff (!resetn)
    fmode == ppf_pkg::FLT_RESERVED |=> !fltForce_ff)
    else $error("fault forced in reserved mode");
  chk_cycle_set: assert property (@(posedge sys_clk) disable iff (!resetn)
    fmode == ppf_pkg::FLT_CYCLE && srcActive |=> fltForce_ff)
    else $error("cycle fault not forced");
  chk_latch_set: assert property (@(posedge sys_clk) disable iff (!resetn)
    fmode == ppf_pkg::FLT_LATCHED && srcActive |=> fltLatch_ff)
    else $error("fault latch not set");
  chk_latch_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    fltLatch_ff && fmode == ppf_pkg::FLT_LATCHED && !clrLatch |=> fltForce_ff)
    else $error("latched fault released early");
  chk_cycle_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    fltForce_ff && fmode == ppf_pkg::FLT_CYCLE && !boundary && $stable(fault_ff) |=> fltForce_ff)
    else $error("cycle fault released off boundary");

  // pin levels under fault, current limit and override
  chk_fault_out: assert property (@(posedge sys_clk) disable iff (!resetn)
    fltForce_ff && $stable(genctl_ff) && $stable(ioctl_ff) |=> pinOut.high ==
    ($past(ioctl_ff[ppf_pkg::IO_FLTDAT_H]) ^ genctl_ff[ppf_pkg::GC_HIGH_SIDE_POLARITY]))
    else $error("fault data not driven");
  chk_limit_high: assert property (@(posedge sys_clk) disable iff (!resetn)
    !fltForce_ff && currentLimit && fault_ff[ppf_pkg::FC_CLEN] && !fault_ff[ppf_pkg::FC_INDEP] |=>
    pinOut.high == ($past(ioctl_ff[ppf_pkg::IO_CURRENT_LIMIT_DATA_HI]) ^ $past(genctl_ff[ppf_pkg::GC_HIGH_SIDE_POLARITY])))
    else $error("limit data high not driven");
  chk_limit_low: assert property (@(posedge sys_clk) disable iff (!resetn)
    !fltForce_ff && currentLimit && fault_ff[ppf_pkg::FC_CLEN] && !fault_ff[ppf_pkg::FC_INDEP] |=>
    pinOut.low == ($past(ioctl_ff[ppf_pkg::IO_CURRENT_LIMIT_DATA_LO]) ^ $past(genctl_ff[ppf_pkg::GC_POLL])))
    else $error("limit data low not driven");
  chk_override_sync_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    ioctl_ff[ppf_pkg::IO_OVERRIDE_SYNC] && !boundary |=> $stable(ovrAct_ff) && $stable(ovrEnAct_ff))
    else $error("synced override applied off boundary");

  // register port answers only in the cycle after a read
  chk_rdata_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    !regRd |=> regRdata == '0)
    else $error("read data without read strobe");
endmodule

// ===== tb/ppf_fault_src.sv
/*
  fault source model for ppf_channel: drives one fault or comparator line.
  assumes code and polarity follow the channel's fault control setting.
*/
`timescale 1ns/1ns
module ppf_fault_src (
  input wire logic [4:0] srcCode,
  input wire logic srcLow,
  input wire logic srcOn,
  output logic [11:0] faultPins,
  output logic [3:0] cmpOuts
);
  logic [15:0] act;
  // ==========================================================================
  // one-hot activity over the sixteen source codes
  always_comb begin
    act = 16'h0000;
    if (srcOn && srcCode >= 5'h01 && srcCode <= 5'h10) begin
      act[srcCode - 5'h01] = 1'h1;
    end
  end
  // idle lines rest at the inactive level of the chosen polarity
  assign faultPins = act[11:0] ^ {12{srcLow}};
  assign cmpOuts = act[15:12] ^ {4{srcLow}};
endmodule

// ===== tb/tb.sv
/*
  bench for ppf_channel: register tasks and directed sequences.
  assumes ppf_pkg and ppf_fault_src are compiled first.
*/
`timescale 1ns/1ns
module tb;
  // ==========================================================================
  // signals
  logic sys_clk = 1'h0, resetn = 1'h0, regWr = 1'h0, regRd = 1'h0, currentLimit = 1'h0;
  logic moduleEnable = 1'h0, masterBoundary = 1'h0, srcOn = 1'h0, srcLow = 1'h0;
  logic localBoundary, adcTrigger, trigIrq;
  logic [2:0] regAddr = 3'h0;
  logic [4:0] srcCode = 5'h00;
  logic [11:0] faultPins;
  logic [3:0] cmpOuts;
  logic [15:0] regWdata = 16'h0000, masterPeriod = 16'h0100;
  logic [15:0] regRdata, phaseHigh, phaseLow, localPeriod, rv;
  ppf_pkg::ppf_pair_t genRaw = 2'h2, pinOut;
  int errTotal = 0, compares = 0, nAdc, nIrq;
  logic [2:0] idx [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  logic [15:0] rst [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0003, 16'h0000, 16'h0000};
  logic [4:0] codes [4] = '{5'h01, 5'h0C, 5'h0D, 5'h10};
  logic [1:0] modes [4] = '{2'h1, 2'h1, 2'h0, 2'h0};
  ppf_channel DUT (.sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .moduleEnable(moduleEnable),
    .masterPeriod(masterPeriod), .masterBoundary(masterBoundary), .genRaw(genRaw),
    .faultPins(faultPins), .cmpOuts(cmpOuts), .currentLimit(currentLimit), .pinOut(pinOut),
    .phaseHigh(phaseHigh), .phaseLow(phaseLow), .localPeriod(localPeriod),
    .localBoundary(localBoundary), .adcTrigger(adcTrigger), .trigIrq(trigIrq));
  ppf_fault_src PARTNER (.srcCode(srcCode), .srcLow(srcLow), .srcOn(srcOn),
    .faultPins(faultPins), .cmpOuts(cmpOuts));
  // ==========================================================================
  // clock and tasks
  always #10 sys_clk = ~sys_clk;
  task automatic conclude();
    $display("compares=%0d errors=%0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errTotal++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmpPin(input ppf_pkg::ppf_pair_t exp);
    compares++;
    if (pinOut !== exp) begin
      errTotal++;
      $display("FAIL t=%0t got=%h exp=%h", $time, pinOut, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'h0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge sys_clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'h0;
    #1 rv = regRdata;
  endtask
  // settings change only while the module is disabled
  task automatic cfg(input logic [15:0] io, input logic [15:0] fc);
    @(posedge sys_clk);
    moduleEnable <= 1'h0;
    wr(ppf_pkg::ADDR_IOCTL, io);
    wr(ppf_pkg::ADDR_FAULT, fc);
    @(posedge sys_clk);
    moduleEnable <= 1'h1;
    tick(6);
  endtask
  task automatic pulse();
    @(posedge sys_clk);
    masterBoundary <= 1'h1;
    @(posedge sys_clk);
    masterBoundary <= 1'h0;
  endtask
  // waits for a local period end, counting trigger pulses meanwhile
  task automatic waitLb();
    logic pa, pi;
    pa = 1'h0;
    pi = 1'h0;
    nAdc = 0;
    nIrq = 0;
    repeat (300) begin
      @(posedge sys_clk);
      #1;
      nAdc += (adcTrigger === 1'h1 && pa !== 1'h1);
      nIrq += (trigIrq === 1'h1 && pi !== 1'h1);
      pa = adcTrigger;
      pi = trigIrq;
      if (localBoundary === 1'h1) break;
    end
  endtask
  // ==========================================================================
  // sequences
  initial begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'h1;
    foreach (idx[i]) begin
      rd(idx[i]);
      cmp(rv, rst[i]);
    end
    wr(ppf_pkg::ADDR_TRIG, 16'hFFFF);
    rd(ppf_pkg::ADDR_TRIG);
    cmp(rv, 16'hFFF8);
    wr(ppf_pkg::ADDR_STRIG, 16'hFFFF);
    rd(ppf_pkg::ADDR_STRIG);
    cmp(rv, 16'hFFF8);
    cfg(16'h0002, 16'h0003);
    cmpPin(2'h1);
    cfg(16'h0000, 16'h0003);
    cmpPin(2'h2);
    // current limit data, polarity, independent fault mode
    genRaw <= 2'h1;
    currentLimit <= 1'h1;
    cfg(16'h0008, 16'h0103);
    cmpPin(2'h2);
    wr(ppf_pkg::ADDR_GENCTL, 16'h0002);
    tick(4);
    cmpPin(2'h0);
    wr(ppf_pkg::ADDR_GENCTL, 16'h0000);
    cfg(16'h0008, 16'h8103);
    cmpPin(2'h1);
    currentLimit <= 1'h0;
    genRaw <= 2'h2;
    // synchronised override waits for the boundary, plain one does not
    cfg(16'h0201, 16'h0003);
    cmpPin(2'h2);
    pulse();
    tick(4);
    cmpPin(2'h0);
    cfg(16'h0140, 16'h0003);
    cmpPin(2'h3);
    // fault sources in cycle and latched modes, both polarities
    for (int i = 0; i < 4; i++) begin
      wr(ppf_pkg::ADDR_FAULT, 16'h0003);
      srcCode <= codes[i];
      srcLow <= i[0];
      cfg(16'h0010, {8'h00, codes[i], i[0], modes[i]});
      cmpPin(2'h2);
      srcOn <= 1'h1;
      tick(8);
      cmpPin(2'h1);
      srcOn <= 1'h0;
      tick(8);
      cmpPin(2'h1);
      pulse();
      tick(6);
      cmpPin(modes[i][0] ? 2'h2 : 2'h1);
      wr(ppf_pkg::ADDR_GENCTL, 16'h0008);
      pulse();
      tick(6);
      cmpPin(2'h2);
    end
    for (int m = 2; m < 4; m++) begin
      srcCode <= 5'h01;
      srcLow <= 1'h0;
      cfg(16'h0010, {8'h00, 5'h01, 1'h0, 2'(m)});
      srcOn <= 1'h1;
      tick(8);
      cmpPin(2'h2);
      srcOn <= 1'h0;
    end
    // phase offset, local period and update timing
    cfg(16'h0000, 16'h0003);
    wr(ppf_pkg::ADDR_GENCTL, 16'h0001);
    wr(ppf_pkg::ADDR_PHASE, 16'h0040);
    tick(2);
    cmp(phaseHigh, 16'h0040);
    cmp(phaseLow, 16'h0040);
    wr(ppf_pkg::ADDR_PHASE, 16'h0200);
    tick(2);
    cmp(phaseHigh, 16'h0100);
    cfg(16'h0C00, 16'h0003);
    wr(ppf_pkg::ADDR_PHASE, 16'h0050);
    tick(2);
    cmp(phaseHigh, 16'h0050);
    cmp(phaseLow, 16'h0000);
    wr(ppf_pkg::ADDR_GENCTL, 16'h0201);
    wr(ppf_pkg::ADDR_PHASE, 16'hFFFF);
    rd(ppf_pkg::ADDR_PHASE);
    cmp(rv, 16'hFFF8);
    cmp(localPeriod, 16'hFFF8);
    wr(ppf_pkg::ADDR_PHASE, 16'h0030);
    tick(2);
    cmp(localPeriod, 16'h0030);
    waitLb();
    wr(ppf_pkg::ADDR_GENCTL, 16'h0200);
    wr(ppf_pkg::ADDR_PHASE, 16'h0020);
    tick(1);
    cmp(localPeriod, 16'h0030);
    wr(ppf_pkg::ADDR_TRIG, 16'h0008);
    wr(ppf_pkg::ADDR_STRIG, 16'h0018);
    waitLb();
    tick(2);
    cmp(localPeriod, 16'h0020);
    waitLb();
    cmp(16'(nAdc), 16'h0002);
    cmp(16'(nIrq), 16'h0001);
    conclude();
  end
  // watchdog cuts a hang short
  initial begin
    #400000;
    errTotal++;
    conclude();
  end
endmodule
